// file: pcsm_pkg.sv
// Package for the PCS management status and negotiation register bank.
// Assumes a 5-bit management register address and 16-bit register data.
`default_nettype none

package pcsm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses on the management port.
    localparam logic [4:0] ADDR_LINK_STATUS = 5'h01;
    localparam logic [4:0] ADDR_IDENT_HIGH = 5'h02;
    localparam logic [4:0] ADDR_IDENT_LOW = 5'h03;
    localparam logic [4:0] ADDR_ADVERTISE = 5'h04;
    localparam logic [4:0] ADDR_PARTNER = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_EXT_STATUS = 5'h0f;

    ////////////////////////////////////////////////////////////////////////
    // Bit positions.
    localparam int BIT_EXT_STATUS = 8;
    localparam int BIT_PREAMBLE = 6;
    localparam int BIT_NEG_DONE = 5;
    localparam int BIT_FAULT = 4;
    localparam int BIT_NEG_CAP = 3;
    localparam int BIT_LINK = 2;
    localparam int BIT_EXT_REGS = 0;
    localparam int BIT_ACK = 14;
    localparam int BIT_PAGE = 1;
    localparam int BIT_NEXT_PAGE = 2;
    localparam int ADV_RO_BIT = 14;
    localparam int ADV_R_BIT = 10;
    localparam int FAULT_HI = 13;
    localparam int FAULT_LO = 12;

    ////////////////////////////////////////////////////////////////////////
    // Fixed and reset values.
    localparam logic [15:0] STATUS_UPPER = 16'h7800;
    localparam logic [15:0] ADV_NONE = 16'h0000;
    localparam logic [15:0] ADV_SGMII_LOW = 16'h9001;
    localparam logic [15:0] ADV_SGMII_GIG = 16'h9801;
    localparam logic [15:0] ADV_BASEX = 16'h0020;
    localparam logic [15:0] ADV_WRITE_MASK = 16'hbfff;
    localparam logic [15:0] EXT_STATUS_VALUE = 16'h8000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pcsm_req_t;

    typedef struct packed {
        logic col;
        logic rx_dv;
        logic [1:0] rxd;
        logic mode_select_out_pin;
    } pcsm_strap_t;

endpackage

`default_nettype wire

// file: pcsm_regs.sv
// Management status, identifier and negotiation registers of a serial PCS.
// Assumes the management frame logic runs on mclk and presents one-cycle
// read and write strobes; strap pins and loss of signal are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module pcsm_regs #(
    // Arbitrary identifier values.
    parameter logic [15:0] IDENT_HIGH = 16'h5a3c,
    parameter logic [15:0] IDENT_LOW = 16'h6c15
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire pcsm_pkg::pcsm_req_t mgmt_req,
    output logic [15:0] rd_data,
    output logic [15:0] advertise_word,
    input wire logic basex_mode,
    input wire logic negotiation_done_in,
    input wire logic pcs_link_up,
    input wire logic cdr_lock_lost,
    input wire logic loss_of_signal_in,
    input wire logic partner_word_valid,
    input wire logic [15:0] partner_word_in,
    input wire pcsm_pkg::pcsm_strap_t strap_pins,
    output logic strap_done,
    output logic [1:0] interrupt_flags
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic los_meta;
    logic los_sync;
    pcsm_pkg::pcsm_strap_t strap_meta;
    pcsm_pkg::pcsm_strap_t strap_sync;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            los_meta <= 1'b0;
            los_sync <= 1'b0;
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            los_meta <= loss_of_signal_in;
            los_sync <= los_meta;
            strap_meta <= strap_pins;
            strap_sync <= strap_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access decode.
    logic rd_status;
    logic rd_expansion;
    logic wr_advertise;

    assign rd_status = mgmt_req.rd &&
        (mgmt_req.addr == pcsm_pkg::ADDR_LINK_STATUS);
    assign rd_expansion = mgmt_req.rd &&
        (mgmt_req.addr == pcsm_pkg::ADDR_EXPANSION);
    assign wr_advertise = mgmt_req.wr && strap_done &&
        (mgmt_req.addr == pcsm_pkg::ADDR_ADVERTISE);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture after reset release.
    logic [1:0] strap_cnt;
    logic [15:0] strap_value;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            strap_done <= (strap_cnt == pcsm_pkg::STRAP_WAIT);
        end
    end

    always_comb begin
        if (!strap_sync.col && !strap_sync.rx_dv) begin
            strap_value = pcsm_pkg::ADV_NONE;
        end else if (!strap_sync.col && !strap_sync.rxd[1]) begin
            strap_value = pcsm_pkg::ADV_SGMII_LOW;
            strap_value[pcsm_pkg::ADV_R_BIT] = strap_sync.rxd[0];
        end else if (strap_sync.mode_select_out_pin) begin
            strap_value = pcsm_pkg::ADV_BASEX;
        end else begin
            strap_value = pcsm_pkg::ADV_SGMII_GIG;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Advertisement register.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            advertise_word <= pcsm_pkg::ADV_NONE;
        end else if (!strap_done) begin
            advertise_word <= strap_value;
        end else if (wr_advertise) begin
            advertise_word <= mgmt_req.wdata &
                pcsm_pkg::ADV_WRITE_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Partner word and page flag.
    logic [15:0] partner_word;
    logic page_flag;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            partner_word <= pcsm_pkg::ZERO_WORD;
        end else if (partner_word_valid) begin
            partner_word <= partner_word_in;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            page_flag <= 1'b0;
        end else if (partner_word_valid) begin
            page_flag <= 1'b1;
        end else if (rd_expansion) begin
            page_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched fault and link flags.
    logic fault_now;
    logic far_end_fault_latched;
    logic link_up_latched;

    assign fault_now = basex_mode ?
        (partner_word[pcsm_pkg::FAULT_HI:pcsm_pkg::FAULT_LO] != 2'h0) :
        (los_sync || cdr_lock_lost);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            far_end_fault_latched <= 1'b0;
        end else if (fault_now) begin
            far_end_fault_latched <= 1'b1;
        end else if (rd_status) begin
            far_end_fault_latched <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            link_up_latched <= 1'b0;
        end else if (!pcs_link_up) begin
            link_up_latched <= 1'b0;
        end else if (rd_status) begin
            link_up_latched <= 1'b1;
        end
    end

    assign interrupt_flags = {link_up_latched, far_end_fault_latched};

    ////////////////////////////////////////////////////////////////////////
    // Read data.
    logic [15:0] status_word;
    logic [15:0] expansion_word;

    always_comb begin
        status_word = pcsm_pkg::STATUS_UPPER;
        status_word[pcsm_pkg::BIT_EXT_STATUS] = 1'b1;
        status_word[pcsm_pkg::BIT_PREAMBLE] = 1'b1;
        status_word[pcsm_pkg::BIT_NEG_DONE] = negotiation_done_in;
        status_word[pcsm_pkg::BIT_FAULT] = far_end_fault_latched;
        status_word[pcsm_pkg::BIT_NEG_CAP] = 1'b1;
        status_word[pcsm_pkg::BIT_LINK] = link_up_latched;
        status_word[pcsm_pkg::BIT_EXT_REGS] = 1'b1;
        expansion_word = pcsm_pkg::ZERO_WORD;
        expansion_word[pcsm_pkg::BIT_PAGE] = page_flag;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= pcsm_pkg::ZERO_WORD;
        end else if (mgmt_req.rd) begin
            case (mgmt_req.addr)
                pcsm_pkg::ADDR_LINK_STATUS: rd_data <= status_word;
                pcsm_pkg::ADDR_IDENT_HIGH: rd_data <= IDENT_HIGH;
                pcsm_pkg::ADDR_IDENT_LOW: rd_data <= IDENT_LOW;
                pcsm_pkg::ADDR_ADVERTISE: rd_data <= advertise_word;
                pcsm_pkg::ADDR_PARTNER: rd_data <= partner_word;
                pcsm_pkg::ADDR_EXPANSION: rd_data <= expansion_word;
                pcsm_pkg::ADDR_EXT_STATUS: begin
                    rd_data <= pcsm_pkg::EXT_STATUS_VALUE;
                end
                default: rd_data <= pcsm_pkg::ZERO_WORD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_extended_capability_status_bit: assert property (
        rd_status |=> rd_data[pcsm_pkg::BIT_EXT_STATUS])
        else $error("Extended status bit not set.");

    a_preamble_bit: assert property (
        rd_status |=> rd_data[pcsm_pkg::BIT_PREAMBLE])
        else $error("Preamble suppression bit not set.");

    a_neg_done_bit: assert property (
        rd_status |=> rd_data[pcsm_pkg::BIT_NEG_DONE] ==
            $past(negotiation_done_in))
        else $error("Negotiation done bit wrong.");

    a_fault_sgmii_set: assert property (
        (!basex_mode && (los_sync || cdr_lock_lost)) |=>
            far_end_fault_latched)
        else $error("SGMII fault did not latch.");

    a_fault_basex_set: assert property (
        (basex_mode && partner_word[pcsm_pkg::FAULT_HI:pcsm_pkg::FAULT_LO]
            != 2'h0) |=> far_end_fault_latched)
        else $error("Partner fault did not latch.");

    a_fault_read_clear: assert property (
        (rd_status && !fault_now) |=> !far_end_fault_latched)
        else $error("Fault did not clear on read.");

    a_irq_mirror: assert property (
        rd_status |=> rd_data[pcsm_pkg::BIT_FAULT] ==
            $past(interrupt_flags[0]) && rd_data[pcsm_pkg::BIT_LINK] ==
            $past(interrupt_flags[1]))
        else $error("Interrupt copies differ from latches.");

    a_link_drop_low: assert property (
        !pcs_link_up |=> !link_up_latched)
        else $error("Link latch did not drop.");

    a_link_read_set: assert property (
        (rd_status && pcs_link_up) ##1 pcs_link_up |->
            link_up_latched && rd_data[pcsm_pkg::BIT_LINK] ==
            $past(link_up_latched))
        else $error("Link latch not set by read.");

    a_fixed_caps: assert property (
        rd_status |=> rd_data[pcsm_pkg::BIT_NEG_CAP] &&
            rd_data[pcsm_pkg::BIT_EXT_REGS])
        else $error("Capability bits not set.");

    a_ident_read: assert property (
        (mgmt_req.rd && mgmt_req.addr == pcsm_pkg::ADDR_IDENT_LOW) |=>
            rd_data == IDENT_LOW)
        else $error("Identifier read wrong.");

    a_adv_readback: assert property (
        (mgmt_req.rd && !wr_advertise &&
            mgmt_req.addr == pcsm_pkg::ADDR_ADVERTISE) |=>
            rd_data == $past(advertise_word))
        else $error("Advertisement readback differs.");

    a_adv_no_neg: assert property (
        ($rose(strap_done) && !strap_sync.col && !strap_sync.rx_dv) |->
            advertise_word == pcsm_pkg::ADV_NONE)
        else $error("No-negotiation reset value wrong.");

    a_adv_sgmii_low: assert property (
        ($rose(strap_done) && !strap_sync.col && strap_sync.rx_dv &&
            !strap_sync.rxd[1]) |->
            advertise_word[pcsm_pkg::ADV_R_BIT] == strap_sync.rxd[0])
        else $error("SGMII 10/100 reset value wrong.");

    a_adv_sgmii_gig: assert property (
        ($rose(strap_done) && (strap_sync.col || (strap_sync.rx_dv &&
            strap_sync.rxd[1])) && !strap_sync.mode_select_out_pin) |->
            advertise_word == pcsm_pkg::ADV_SGMII_GIG)
        else $error("SGMII gigabit reset value wrong.");

    a_adv_basex: assert property (
        ($rose(strap_done) && (strap_sync.col || (strap_sync.rx_dv &&
            strap_sync.rxd[1])) && strap_sync.mode_select_out_pin) |->
            advertise_word == pcsm_pkg::ADV_BASEX)
        else $error("1000BASE-X reset value wrong.");

    a_adv_ro_bit: assert property (
        wr_advertise |=> !advertise_word[pcsm_pkg::ADV_RO_BIT] &&
            advertise_word[15] == $past(mgmt_req.wdata[15]))
        else $error("Advertisement write wrong.");

    a_partner_capture: assert property (
        partner_word_valid |=> partner_word == $past(partner_word_in))
        else $error("Partner word not captured.");

    a_page_set: assert property (
        partner_word_valid |=> page_flag)
        else $error("Page flag did not set.");

    a_next_page_zero: assert property (
        rd_expansion |=> !rd_data[pcsm_pkg::BIT_NEXT_PAGE])
        else $error("Next page bit not zero.");

    a_ext_status: assert property (
        (mgmt_req.rd && mgmt_req.addr == pcsm_pkg::ADDR_EXT_STATUS) |=>
            rd_data == pcsm_pkg::EXT_STATUS_VALUE)
        else $error("Extended status value wrong.");

    a_no_stray_clear: assert property (
        (far_end_fault_latched && !rd_status) |=> far_end_fault_latched)
        else $error("Fault cleared without a status read.");

    a_page_hold: assert property (
        (page_flag && !rd_expansion) |=> page_flag)
        else $error("Page flag cleared without an expansion read.");

    c_fault_cleared: cover property (
        far_end_fault_latched ##1 !far_end_fault_latched);
    c_link_set: cover property (!link_up_latched ##1 link_up_latched);
    c_page_read: cover property (page_flag ##1 rd_expansion ##1 !page_flag);
    c_adv_write: cover property (wr_advertise);

endmodule

`default_nettype wire

// file: pcsm_mgmt_model.sv
// Station management model that reads and writes the register bank.
// Assumes one-cycle strobes on mclk and read data valid one edge later.
`timescale 1ns/1ps
`default_nettype none

module pcsm_mgmt_model (
    input wire logic mclk,
    output var pcsm_pkg::pcsm_req_t mgmt_req,
    input wire logic [15:0] rd_data
);

    initial begin
        mgmt_req = 23'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Released address and data show the inverse of their last value.
    task automatic read(input logic [4:0] a, output logic [15:0] d);
        @(negedge mclk);
        mgmt_req.addr = a;
        mgmt_req.rd = 1'b1;
        @(negedge mclk);
        d = rd_data;
        mgmt_req.rd = 1'b0;
        mgmt_req.addr = ~a;
    endtask

    task automatic write(input logic [4:0] a, input logic [15:0] w);
        @(negedge mclk);
        mgmt_req.addr = a;
        mgmt_req.wdata = w;
        mgmt_req.wr = 1'b1;
        @(negedge mclk);
        mgmt_req.wr = 1'b0;
        mgmt_req.addr = ~a;
        mgmt_req.wdata = ~w;
    endtask

endmodule

`default_nettype wire

// file: pcsm_regs_tb.sv
// Self-checking testbench of the status and negotiation register bank.
// Assumes the management model drives the register strobes.
`timescale 1ns/1ps
`default_nettype none

module pcsm_regs_tb;

    // Arbitrary identifier values.
    localparam logic [15:0] ID_HI = 16'h3c96;
    localparam logic [15:0] ID_LO = 16'h4e27;
    localparam logic [4:0] ST = pcsm_pkg::ADDR_LINK_STATUS;
    localparam logic [4:0] EXP = pcsm_pkg::ADDR_EXPANSION;

    logic mclk, reset_n, basex_mode, neg_done, link_up, cdr_lost, los;
    logic pw_valid, strap_done;
    logic [15:0] pw, rd_data, adv;
    logic [1:0] interrupt_flags;
    pcsm_pkg::pcsm_req_t req;
    pcsm_pkg::pcsm_strap_t straps;
    int error_cnt, n_compared, cycles;
    logic [4:0] strap_tab [7] = '{5'h00, 5'h08, 5'h0a, 5'h0c, 5'h0d,
                                  5'h10, 5'h11};
    logic [15:0] adv_tab [7] = '{16'h0000, 16'h9001, 16'h9401, 16'h9801,
                                 16'h0020, 16'h9801, 16'h0020};

    pcsm_regs #(.IDENT_HIGH(ID_HI), .IDENT_LOW(ID_LO)) uut (
        .mclk(mclk),
        .reset_n(reset_n),
        .mgmt_req(req),
        .rd_data(rd_data),
        .advertise_word(adv),
        .basex_mode(basex_mode),
        .negotiation_done_in(neg_done),
        .pcs_link_up(link_up),
        .cdr_lock_lost(cdr_lost),
        .loss_of_signal_in(los),
        .partner_word_valid(pw_valid),
        .partner_word_in(pw),
        .strap_pins(straps),
        .strap_done(strap_done),
        .interrupt_flags(interrupt_flags)
    );

    pcsm_mgmt_model mgmt (
        .mclk(mclk),
        .mgmt_req(req),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and timeout.
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks.
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp,
                          input string what);
        logic [15:0] d;
        mgmt.read(a, d);
        check(what, d, exp);
    endtask

    task automatic irq_chk(input logic [15:0] exp);
        repeat (2) @(negedge mclk);
        check("interrupt_flags", {14'h0, interrupt_flags}, exp);
    endtask

    task automatic do_reset(input logic [4:0] s, input logic [15:0] exp);
        int n;
        @(negedge mclk);
        reset_n = 1'b0;
        straps = s;
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        n = 0;
        while (strap_done !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        check("strap_done", {15'h0, strap_done}, 16'h0001);
        check("advertise_word", adv, exp);
        check("interrupt_flags", {14'h0, interrupt_flags}, 16'h0);
    endtask

    task automatic send_partner(input logic [15:0] w);
        @(negedge mclk);
        pw = w;
        pw_valid = 1'b1;
        @(negedge mclk);
        pw_valid = 1'b0;
        pw = ~w;
    endtask

    task automatic report_and_stop();
        $display("Compared %0d values, %0d mismatches", n_compared,
                 error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    initial begin
        reset_n = 1'b0;
        {basex_mode, neg_done, link_up, cdr_lost, los, pw_valid} = 6'h0;
        pw = 16'h0;
        straps = 5'h0;
        error_cnt = 0;
        n_compared = 0;
        cycles = 0;
        for (int i = 0; i < 7; i++) begin
            do_reset(strap_tab[i], adv_tab[i]);
        end
        rd_chk(ST, 16'h7949, "status");
        rd_chk(pcsm_pkg::ADDR_IDENT_HIGH, ID_HI, "ident high");
        rd_chk(pcsm_pkg::ADDR_IDENT_LOW, ID_LO, "ident low");
        rd_chk(pcsm_pkg::ADDR_EXT_STATUS, 16'h8000, "ext status");
        rd_chk(pcsm_pkg::ADDR_PARTNER, 16'h0, "partner");
        rd_chk(EXP, 16'h0, "expansion");
        rd_chk(5'h07, 16'h0, "unmapped");
        mgmt.write(pcsm_pkg::ADDR_ADVERTISE, 16'hffff);
        check("advertise_word", adv, 16'hbfff);
        rd_chk(pcsm_pkg::ADDR_ADVERTISE, 16'hbfff, "advertise");
        mgmt.write(pcsm_pkg::ADDR_PARTNER, 16'h1234);
        rd_chk(pcsm_pkg::ADDR_PARTNER, 16'h0, "partner ro");
        // Link latch: set by read while up, dropped by a one-cycle loss.
        @(negedge mclk);
        link_up = 1'b1;
        neg_done = 1'b1;
        rd_chk(ST, 16'h7969, "status");
        rd_chk(ST, 16'h796d, "status");
        irq_chk(16'h0002);
        link_up = 1'b0;
        @(negedge mclk);
        link_up = 1'b1;
        rd_chk(ST, 16'h7969, "status");
        rd_chk(ST, 16'h796d, "status");
        // Fault latch from lost lock, untouched by other accesses.
        cdr_lost = 1'b1;
        @(negedge mclk);
        cdr_lost = 1'b0;
        irq_chk(16'h0003);
        mgmt.write(ST, 16'h0);
        rd_chk(pcsm_pkg::ADDR_IDENT_HIGH, ID_HI, "ident high");
        rd_chk(ST, 16'h797d, "status");
        rd_chk(ST, 16'h796d, "status");
        cdr_lost = 1'b1;
        rd_chk(ST, 16'h797d, "status");
        rd_chk(ST, 16'h797d, "status");
        cdr_lost = 1'b0;
        rd_chk(ST, 16'h797d, "status");
        rd_chk(ST, 16'h796d, "status");
        los = 1'b1;
        repeat (3) @(negedge mclk);
        los = 1'b0;
        repeat (4) @(negedge mclk);
        rd_chk(ST, 16'h797d, "status");
        rd_chk(ST, 16'h796d, "status");
        // Partner word, page flag and fault field by mode.
        send_partner(16'h7000);
        rd_chk(pcsm_pkg::ADDR_PARTNER, 16'h7000, "partner");
        rd_chk(ST, 16'h796d, "status");
        rd_chk(EXP, 16'h0002, "expansion");
        rd_chk(EXP, 16'h0000, "expansion");
        basex_mode = 1'b1;
        rd_chk(ST, 16'h797d, "status");
        rd_chk(ST, 16'h797d, "status");
        send_partner(16'h4000);
        rd_chk(ST, 16'h797d, "status");
        rd_chk(ST, 16'h796d, "status");
        rd_chk(EXP, 16'h0002, "expansion");
        report_and_stop();
    end

endmodule

`default_nettype wire
